// ### hdl/slgm_defines.svh
/*
 * Constants of the GPIO mapper: register offsets, field positions, output
 * source and function codes, and back-channel frame timing.
 * Assumes a 50 MHz core clock and 8-bit register data.
 */
`ifndef SLGM_DEFINES_SVH
`define SLGM_DEFINES_SVH

// Register offsets.
`define SLGM_OFF_INPUT_CTRL 8'h0F
`define SLGM_OFF_PIN_CFG0 8'h10
`define SLGM_OFF_PIN_CFG6 8'h16
`define SLGM_OFF_MISC 8'h18
`define SLGM_OFF_PIN_LEVEL 8'h19
`define SLGM_OFF_LINK_CNT 8'h1A
`define SLGM_OFF_BC_MAP_LO 8'h6E
`define SLGM_OFF_BC_MAP_HI 8'h6F
`define SLGM_OFF_PULLDOWN 8'hBE
`define SLGM_RESET_BYTE 8'h00

// Fields of the misc register.
`define SLGM_MISC_PORT_EN 1:0
`define SLGM_MISC_BC_SLOW 2
`define SLGM_MISC_EXT_SYNC 3
`define SLGM_MISC_MAP_PORT 4
// Fields of the link count register.
`define SLGM_LCNT_P0 2:0
`define SLGM_LCNT_P1 6:4

// Output source codes.
`define SLGM_SRC_RX0 3'h0
`define SLGM_SRC_RX1 3'h1
`define SLGM_SRC_DEV 3'h4
`define SLGM_SRC_VO 3'h5
// Function codes.
`define SLGM_FN_0 3'h0
`define SLGM_FN_1 3'h1
`define SLGM_FN_2 3'h2
`define SLGM_FN_3 3'h3
`define SLGM_FN_4 3'h4
`define SLGM_FN_5 3'h5
`define SLGM_FN_6 3'h6
// Back-channel slot code that selects the sync strobe.
`define SLGM_SLOT_SYNC 3'h7

// Back-channel frame timing.
`define SLGM_CLK_NS 20
`define SLGM_BC_FRAME_BITS 30
`define SLGM_BC_FAST_BIT_NS 20
`define SLGM_BC_SLOW_BIT_NS 400
`define SLGM_BC_FAST_CYC \
    (`SLGM_BC_FRAME_BITS * `SLGM_BC_FAST_BIT_NS / `SLGM_CLK_NS)
`define SLGM_BC_SLOW_CYC \
    (`SLGM_BC_FRAME_BITS * `SLGM_BC_SLOW_BIT_NS / `SLGM_CLK_NS)

// Forward update periods in frames.
`define SLGM_FWD_PER_1 3'h1
`define SLGM_FWD_PER_2 3'h2
`define SLGM_FWD_PER_5 3'h5

`endif

// ### hdl/slgm_pkg.sv
/*
 * Types of the GPIO mapper.
 * Assumes slgm_defines.svh gives the codes that fill them.
 */
package slgm_pkg;
    // Per-pin output configuration, laid out as its register byte.
    typedef struct packed {
        logic en;
        logic val;
        logic [2:0] fn;
        logic [2:0] src;
    } slgm_pin_cfg_t;

    // Status of one receive port.
    typedef struct packed {
        logic [3:0] fwd_gpio;
        logic lock;
        logic pass;
        logic fv;
        logic lv;
    } slgm_rx_status_t;

    // Status of the video-output port.
    typedef struct packed {
        logic fv;
        logic lv;
        logic synced;
        logic irq;
    } slgm_vo_status_t;
endpackage : slgm_pkg

// ### hdl/slgm_bc_sampler.sv
/*
 * Back-channel frame timer and slot sampler for both receive ports.
 * Assumes pin levels and sync are already synchronised to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slgm_defines.svh"

module slgm_bc_sampler import slgm_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic slow_rate,
    input wire logic [6:0] pin_level,
    input wire logic sync_level,
    input wire logic [1:0][11:0] slot_map,
    output logic bc_frame_pulse,
    output logic [1:0][3:0] bc_slot_value
);
    localparam logic [9:0] FAST_LAST = 10'(`SLGM_BC_FAST_CYC - 1);
    localparam logic [9:0] SLOW_LAST = 10'(`SLGM_BC_SLOW_CYC - 1);

    logic [9:0] cnt_reg;
    logic [9:0] last;

    ////////////////////////////////////////////////////////////////////////
    // A frame is 30 bit times; the compare is >= so a rate change never
    // strands the counter above the new end.
    assign last = slow_rate ? SLOW_LAST : FAST_LAST;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 10'h000;
            bc_frame_pulse <= 1'b0;
        end else if (cnt_reg >= last) begin // RULE17
            cnt_reg <= 10'h000;
            bc_frame_pulse <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
            bc_frame_pulse <= 1'b0;
        end
    end

    // Slots are sampled once per frame; any pin may feed any slot.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bc_slot_value <= '0;
        end else if (cnt_reg >= last) begin // RULE18
            for (int p = 0; p < 2; p++) begin
                for (int s = 0; s < 4; s++) begin
                    if (slot_map[p][s*3 +: 3] == `SLGM_SLOT_SYNC) begin
                        bc_slot_value[p][s] <= sync_level; // RULE20
                    end else begin
                        bc_slot_value[p][s] <=
                            pin_level[slot_map[p][s*3 +: 3]]; // RULE15 RULE16
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_fast_pulse;
        bc_frame_pulse && !slow_rate;
    endsequence

    a_frame_gap_fast: assert property ( // RULE17
        s_fast_pulse ##1 (!slow_rate)[*8] |-> !bc_frame_pulse)
        else $error("Back-channel frame shorter than 30 bits.");
    a_frame_end_fast: assert property ( // RULE17
        s_fast_pulse ##30 1'b1 |-> bc_frame_pulse || slow_rate)
        else $error("Back-channel frame not 30 cycles at fast rate.");
    a_slot_sampled: assert property ( // RULE18
        !bc_frame_pulse |-> $stable(bc_slot_value))
        else $error("Slot value changed between frames.");
endmodule : slgm_bc_sampler

`default_nettype wire

// ### hdl/slgm_top.sv
/*
 * GPIO mapper of the deserializer: seven pins, output function routing,
 * forward GPIO hold with link-count update rate, back-channel slot feed,
 * input-enable and pulldown controls, and a plain register port.
 * Assumes status inputs and frame pulses come from logic on sys_clk;
 * pin and external sync inputs are asynchronous.
 */
// Added by the designer: the strobed register port.
// Notes on behaviour
// [RULE1] Port sources route forward GPIO or port status.
// [RULE2] Status source: value, lock OR/AND, pass AND.
// [RULE3] Status functions 101/110 give device interrupt polarity.
// [RULE4] Video source 000/001: pass AND/OR of ports.
// [RULE5] Video source 010/011: frame and line valid.
// [RULE6] Video source 100: ports synchronised indication.
// [RULE7] Video source 101: interrupt high; 110/111 reserved.
// [RULE8] Reserved sources and functions leave pin undriven.
// [RULE9] Four forward GPIO per port, any to any pin.
// [RULE10] Forward update every 1, 2 or 5 frames.
// [RULE11] Remote source keeps four-times oversampling.
// [RULE12] Only forward-capable serializers supply forward GPIO.
// [RULE13] Sync strobe may drive any pin.
// [RULE14] All pins start as inputs, driver off.
// [RULE15] Four back-channel slots per port, any pin.
// [RULE16] One pin may feed many slots.
// [RULE17] Back-channel frame is thirty bit times.
// [RULE18] Slots sampled once each back-channel frame.
// [RULE19] Back-channel inputs switch below quarter sampling rate.
// [RULE20] Sync strobe mappable to any back-channel slot.
// [RULE21] Slot map held per port at 0x6E/0x6F.
// [RULE22] Input and pulldown disables, both enabled default.
// [RULE23] Pin drives only while output enable set.
`timescale 1ns/1ps
`default_nettype none
`include "slgm_defines.svh"

module slgm_top import slgm_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire slgm_rx_status_t [1:0] rx_status,
    input wire logic [1:0] fwd_frame_pulse,
    input wire slgm_vo_status_t vo_status,
    input wire logic device_irq,
    input wire logic sensor_sync_strobe,
    input wire logic ext_sync_in,
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe,
    output logic [6:0] pin_input_enable,
    output logic [6:0] pin_pulldown_enable,
    output logic bc_frame_pulse,
    output logic [1:0][3:0] bc_slot_value
);
    slgm_pin_cfg_t pin_cfg_reg [0:6];
    logic [7:0] input_dis_reg;
    logic [7:0] pulldown_dis_reg;
    logic [7:0] misc_reg;
    logic [7:0] link_cnt_reg;
    logic [7:0] bc_map_reg [0:1][0:1];
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic [2:0] fwd_cnt_reg [0:1];
    logic [3:0] fwd_hold_reg [0:1];
    logic [6:0] pin_level;
    logic sync_level;
    logic [1:0] port_en;
    logic [1:0] fwd_update;
    logic [1:0][11:0] slot_map;
    logic map_port;
    logic [2:0] cfg_idx;
    logic [1:0] pin_drv [0:6];

    ////////////////////////////////////////////////////////////////////////
    // Functions.

    // Frames between forward updates for a given linked GPIO count.
    function automatic logic [2:0] fwd_period(input logic [2:0] cnt);
        logic [2:0] per;
        per = `SLGM_FWD_PER_5;
        if (cnt <= 3'h1) begin
            per = `SLGM_FWD_PER_1;
        end else if (cnt == 3'h2) begin
            per = `SLGM_FWD_PER_2;
        end
        return per;
    endfunction : fwd_period

    // Output drive of one pin as {enable, value}.
    function automatic logic [1:0] pin_drive(input slgm_pin_cfg_t cfg,
            input slgm_rx_status_t [1:0] rx, input logic [3:0] fwd0,
            input logic [3:0] fwd1, input logic [1:0] en,
            input slgm_vo_status_t vo, input logic irq, input logic sync);
        logic [1:0] drv;
        slgm_rx_status_t st;
        logic [3:0] fwd;
        drv = 2'h0;
        st = rx[cfg.src[0]];
        fwd = cfg.src[0] ? fwd1 : fwd0;
        unique case (cfg.src)
            `SLGM_SRC_RX0, `SLGM_SRC_RX1: begin
                unique case (cfg.fn)
                    `SLGM_FN_4: drv = {1'b1, st.lock};
                    `SLGM_FN_5: drv = {1'b1, st.pass};
                    `SLGM_FN_6: drv = {1'b1, st.fv};
                    `SLGM_FN_0, `SLGM_FN_1, `SLGM_FN_2, `SLGM_FN_3:
                        drv = {1'b1, fwd[cfg.fn[1:0]]}; // RULE1 RULE9
                    default: drv = {1'b1, st.lv};
                endcase
            end
            `SLGM_SRC_DEV: begin
                unique case (cfg.fn)
                    `SLGM_FN_0: drv = {1'b1, cfg.val}; // RULE2
                    `SLGM_FN_1: drv = {1'b1,
                        |({rx[1].lock, rx[0].lock} & en)}; // RULE2
                    `SLGM_FN_2: drv = {1'b1,
                        &({rx[1].lock, rx[0].lock} | ~en)}; // RULE2
                    `SLGM_FN_3: drv = {1'b1,
                        &({rx[1].pass, rx[0].pass} | ~en)}; // RULE2
                    `SLGM_FN_4: drv = {1'b1, sync}; // RULE13
                    `SLGM_FN_5: drv = {1'b1, irq}; // RULE3
                    `SLGM_FN_6: drv = {1'b1, !irq}; // RULE3
                    default: drv = 2'h0; // RULE8
                endcase
            end
            `SLGM_SRC_VO: begin
                unique case (cfg.fn)
                    `SLGM_FN_0: drv = {1'b1,
                        &({rx[1].pass, rx[0].pass} | ~en)}; // RULE4
                    `SLGM_FN_1: drv = {1'b1,
                        |({rx[1].pass, rx[0].pass} & en)}; // RULE4
                    `SLGM_FN_2: drv = {1'b1, vo.fv}; // RULE5
                    `SLGM_FN_3: drv = {1'b1, vo.lv}; // RULE5
                    `SLGM_FN_4: drv = {1'b1, vo.synced}; // RULE6
                    `SLGM_FN_5: drv = {1'b1, vo.irq}; // RULE7
                    default: drv = 2'h0; // RULE7 RULE8
                endcase
            end
            default: drv = 2'h0; // RULE8
        endcase
        return drv;
    endfunction : pin_drive

    ////////////////////////////////////////////////////////////////////////
    // Pin and external sync synchronisers; the first stage feeds only the
    // second, so a metastable sample never reaches the mapping logic.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= 7'h00;
            pin_sync_reg <= 7'h00;
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            ext_meta_reg <= ext_sync_in;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // A disabled input reads as low, as the input buffer is off.
    assign pin_level = pin_sync_reg & ~input_dis_reg[6:0]; // RULE22
    assign sync_level = misc_reg[`SLGM_MISC_EXT_SYNC] ? ext_sync_reg
                                                      : sensor_sync_strobe;
    assign port_en = misc_reg[`SLGM_MISC_PORT_EN];
    assign map_port = misc_reg[`SLGM_MISC_MAP_PORT];
    assign cfg_idx = 3'(reg_addr - `SLGM_OFF_PIN_CFG0);

    ////////////////////////////////////////////////////////////////////////
    // Register writes. All clear to zero, so every pin starts as an input
    // with its input path and pulldown enabled.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 7; i++) begin
                pin_cfg_reg[i] <= `SLGM_RESET_BYTE; // RULE14
            end
            input_dis_reg <= `SLGM_RESET_BYTE; // RULE22
            pulldown_dis_reg <= `SLGM_RESET_BYTE; // RULE22
            misc_reg <= `SLGM_RESET_BYTE;
            link_cnt_reg <= `SLGM_RESET_BYTE;
        end else if (reg_wr) begin
            if (reg_addr >= `SLGM_OFF_PIN_CFG0 &&
                    reg_addr <= `SLGM_OFF_PIN_CFG6) begin
                pin_cfg_reg[cfg_idx] <= reg_wdata;
            end
            if (reg_addr == `SLGM_OFF_INPUT_CTRL) begin
                input_dis_reg <= reg_wdata; // RULE22
            end
            if (reg_addr == `SLGM_OFF_PULLDOWN) begin
                pulldown_dis_reg <= reg_wdata; // RULE22
            end
            if (reg_addr == `SLGM_OFF_MISC) begin
                misc_reg <= reg_wdata;
            end
            if (reg_addr == `SLGM_OFF_LINK_CNT) begin
                link_cnt_reg <= reg_wdata;
            end
        end
    end

    // Slot maps, one pair per port, chosen by the map-port select bit.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < 2; p++) begin
                bc_map_reg[p][0] <= `SLGM_RESET_BYTE;
                bc_map_reg[p][1] <= `SLGM_RESET_BYTE;
            end
        end else if (reg_wr && reg_addr == `SLGM_OFF_BC_MAP_LO) begin
            bc_map_reg[map_port][0] <= reg_wdata; // RULE21
        end else if (reg_wr && reg_addr == `SLGM_OFF_BC_MAP_HI) begin
            bc_map_reg[map_port][1] <= reg_wdata; // RULE21
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr >= `SLGM_OFF_PIN_CFG0 &&
                reg_addr <= `SLGM_OFF_PIN_CFG6) begin
            reg_rdata <= pin_cfg_reg[cfg_idx];
        end else begin
            unique case (reg_addr)
                `SLGM_OFF_INPUT_CTRL: reg_rdata <= input_dis_reg;
                `SLGM_OFF_PULLDOWN: reg_rdata <= pulldown_dis_reg;
                `SLGM_OFF_MISC: reg_rdata <= misc_reg;
                `SLGM_OFF_LINK_CNT: reg_rdata <= link_cnt_reg;
                `SLGM_OFF_PIN_LEVEL: reg_rdata <= {1'b0, pin_level};
                `SLGM_OFF_BC_MAP_LO: reg_rdata <= bc_map_reg[map_port][0];
                `SLGM_OFF_BC_MAP_HI: reg_rdata <= bc_map_reg[map_port][1];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Forward GPIO hold. Linked values are spread over frames, so the held
    // copy changes only on the frame that completes an update. A count of
    // zero means nothing linked and behaves like one.
    assign fwd_update[0] = fwd_frame_pulse[0] &&
        fwd_cnt_reg[0] >= fwd_period(link_cnt_reg[`SLGM_LCNT_P0]) - 3'h1;
    assign fwd_update[1] = fwd_frame_pulse[1] &&
        fwd_cnt_reg[1] >= fwd_period(link_cnt_reg[`SLGM_LCNT_P1]) - 3'h1;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < 2; p++) begin
                fwd_cnt_reg[p] <= 3'h0;
                fwd_hold_reg[p] <= 4'h0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (fwd_update[p]) begin
                    fwd_cnt_reg[p] <= 3'h0; // RULE10
                    fwd_hold_reg[p] <= rx_status[p].fwd_gpio; // RULE9
                end else if (fwd_frame_pulse[p]) begin
                    fwd_cnt_reg[p] <= fwd_cnt_reg[p] + 3'h1; // RULE10
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Function mux of every pin; the flip-flops below gate it with the enable bit and register it.
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_drv[i] = pin_drive(pin_cfg_reg[i], rx_status,
                fwd_hold_reg[0], fwd_hold_reg[1], port_en, vo_status,
                device_irq, sync_level);
        end
    end

    // Pin drive; the enable bit gates the driver after the function mux.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= 7'h00;
            pin_oe <= 7'h00; // RULE14
        end else begin
            for (int i = 0; i < 7; i++) begin
                pin_oe[i] <= pin_cfg_reg[i].en && pin_drv[i][1]; // RULE23
                pin_out[i] <= pin_cfg_reg[i].en && pin_drv[i][0]; // RULE23
            end
        end
    end

    // Pad controls follow the disable bits one cycle later.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_input_enable <= 7'h7F; // RULE22
            pin_pulldown_enable <= 7'h7F; // RULE22
        end else begin
            pin_input_enable <= ~input_dis_reg[6:0];
            pin_pulldown_enable <= ~pulldown_dis_reg[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Back-channel slots; both slot bytes of a port form one 12-bit map.
    assign slot_map[0] = {bc_map_reg[0][1][6:4], bc_map_reg[0][1][2:0],
                          bc_map_reg[0][0][6:4], bc_map_reg[0][0][2:0]};
    assign slot_map[1] = {bc_map_reg[1][1][6:4], bc_map_reg[1][1][2:0],
                          bc_map_reg[1][0][6:4], bc_map_reg[1][0][2:0]};

    slgm_bc_sampler u_bc_sampler (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .slow_rate(misc_reg[`SLGM_MISC_BC_SLOW]),
        .pin_level(pin_level),
        .sync_level(sync_level),
        .slot_map(slot_map),
        .bc_frame_pulse(bc_frame_pulse),
        .bc_slot_value(bc_slot_value)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    slgm_pin_cfg_t c0;
    assign c0 = pin_cfg_reg[0];

    a_oe_needs_enable: assert property ( // RULE23
        pin_oe[0] |-> $past(c0.en))
        else $error("Pin 0 driven without output enable.");
    a_reserved_src_off: assert property ( // RULE8
        c0.src == 3'h2 || c0.src >= 3'h6 |=> !pin_oe[0])
        else $error("Reserved source drives pin 0.");
    a_fwd_map_pin: assert property ( // RULE1
        c0.en && c0.src == `SLGM_SRC_RX1 && c0.fn == `SLGM_FN_2
        |=> pin_oe[0] && pin_out[0] == $past(fwd_hold_reg[1][2]))
        else $error("Forward GPIO 2 of port 1 not on pin 0.");
    a_status_value: assert property ( // RULE2
        c0.en && c0.src == `SLGM_SRC_DEV && c0.fn == `SLGM_FN_0
        |=> pin_out[0] == $past(c0.val))
        else $error("Programmed value not on pin 0.");
    a_irq_low: assert property ( // RULE3
        c0.en && c0.src == `SLGM_SRC_DEV && c0.fn == `SLGM_FN_6
        |=> pin_out[0] == !$past(device_irq))
        else $error("Active-low interrupt wrong on pin 0.");
    a_pass_or: assert property ( // RULE4
        c0.en && c0.src == `SLGM_SRC_VO && c0.fn == `SLGM_FN_1
        |=> pin_out[0] == $past(|({rx_status[1].pass,
                                   rx_status[0].pass} & port_en)))
        else $error("Pass OR wrong on pin 0.");
    a_line_valid: assert property ( // RULE5
        c0.en && c0.src == `SLGM_SRC_VO && c0.fn == `SLGM_FN_3
        |=> pin_out[0] == $past(vo_status.lv))
        else $error("Line valid not on pin 0.");
    a_vo_reserved: assert property ( // RULE7
        c0.src == `SLGM_SRC_VO && c0.fn >= `SLGM_FN_6 |=> !pin_oe[0])
        else $error("Reserved video function drives pin 0.");
    a_fwd_hold: assert property ( // RULE10
        !fwd_frame_pulse[0] |=> $stable(fwd_hold_reg[0]))
        else $error("Forward value changed without a frame.");
endmodule : slgm_top

`default_nettype wire

// ### bench/slgm_remote_model.sv
/*
 * Model of one remote serializer: forward frame pulses and forward GPIO.
 * Assumes the mapper samples its status inputs on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module slgm_remote_model import slgm_pkg::*; #(
    parameter int FRAME_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [3:0] gpio_set,
    output slgm_rx_status_t status,
    output logic frame_pulse
);
    int cnt;

    // GPIO values move only at frame ends, as a real link would send them.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            frame_pulse <= 1'b0;
            status <= '0;
        end else begin
            cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
            frame_pulse <= (cnt == FRAME_CYC - 1);
            if (cnt == FRAME_CYC - 1) begin
                status.fwd_gpio <= gpio_set;
                status.lock <= 1'b1;
                status.pass <= 1'b1;
            end
        end
    end
endmodule : slgm_remote_model

`default_nettype wire

// ### bench/serial_link_gpio_mapper_test.sv
/*
 * Self-checking bench of the GPIO mapper.
 * Assumes a 50 MHz sys_clk and two remote serializer models.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_link_gpio_mapper_test import slgm_pkg::*; ;
    logic sys_clk, resetn, reg_wr, reg_rd, dirq, sync;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [6:0] pin_in, pin_out, pin_oe, pin_ie, pin_pd;
    logic [3:0] g0;
    logic [1:0] fp;
    logic bc_pulse;
    logic [1:0][3:0] slot;
    slgm_rx_status_t [1:0] rx;
    slgm_vo_status_t vo;
    int errors, checks, cyc, n;

    slgm_remote_model m0 (.sys_clk(sys_clk), .resetn(resetn),
        .gpio_set(g0), .status(rx[0]), .frame_pulse(fp[0]));
    slgm_remote_model m1 (.sys_clk(sys_clk), .resetn(resetn),
        .gpio_set(4'h0), .status(rx[1]), .frame_pulse(fp[1]));
    slgm_top dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_status(rx), .fwd_frame_pulse(fp),
        .vo_status(vo), .device_irq(dirq), .sensor_sync_strobe(sync),
        .ext_sync_in(1'b0), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_input_enable(pin_ie),
        .pin_pulldown_enable(pin_pd), .bc_frame_pulse(bc_pulse),
        .bc_slot_value(slot));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared bus, wait and compare helpers.
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdr(logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr
    task automatic w(int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : w
    task automatic wp();
        n = 0;
        do begin
            w(1);
            n++;
        end while (bc_pulse !== 1'b1 && n < 700);
    endtask : wp

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_dev();
        wr(8'h10, 8'hC4);
        w(2);
        chk("out0", 8'h01, 8'(pin_out[0]));
        chk("oe0", 8'h01, 8'(pin_oe[0]));
        rdr(8'h10);
        chk("cfg0", 8'hC4, rd);
        rdr(8'h55);
        chk("unmapped", 8'h00, rd);
        wr(8'h10, 8'h44);
        w(2);
        chk("oe0 off", 8'h00, 8'(pin_oe[0]));
    endtask : t_dev
    task automatic t_irq();
        wr(8'h11, 8'hAC);
        dirq <= 1'b1;
        w(2);
        chk("irq hi", 8'h01, 8'(pin_out[1]));
        wr(8'h11, 8'hB4);
        w(2);
        chk("irq lo", 8'h00, 8'(pin_out[1]));
        wr(8'h11, 8'hBC);
        wr(8'h12, 8'h82);
        w(2);
        chk("rsv oe", 8'h00, 8'(pin_oe[2:1]));
    endtask : t_irq
    task automatic t_vo_fwd();
        wr(8'h13, 8'hA5);
        vo.synced <= 1'b1;
        g0 <= 4'h1;
        wr(8'h14, 8'h80);
        wr(8'h15, 8'hA0);
        w(20);
        chk("synced", 8'h01, 8'(pin_out[3]));
        chk("fwd", 8'h01, 8'(pin_out[4]));
        chk("lock", 8'h01, 8'(pin_out[5]));
    endtask : t_vo_fwd
    // Three or four linked values: one update every fifth forward frame.
    task automatic t_fwd();
        wr(8'h1A, 8'h03);
        g0 <= 4'h0;
        do begin
            w(1);
        end while (pin_out[4] !== 1'b0);
        // Each level is held two update periods, keeping 4x oversampling.
        repeat (40) @(posedge sys_clk);
        g0 <= 4'h1;
        n = 0;
        do begin
            w(1);
            if (fp[0] === 1'b1) n++;
        end while (pin_out[4] !== 1'b1);
        chk("fwd period", 16'd5, 16'(n));
    endtask : t_fwd
    task automatic t_bc();
        wr(8'h18, 8'h01);
        pin_in <= 7'h08;
        sync <= 1'b1;
        wr(8'h6E, 8'h73);
        wr(8'h6F, 8'h03);
        wp();
        wp();
        wp();
        chk("period", 8'd30, 8'(n));
        chk("slots", 8'h07, 8'(slot));
        wr(8'h18, 8'h05);
        wp();
        wp();
        chk("slow period", 16'd600, 16'(n));
    endtask : t_bc
    task automatic t_inp();
        wr(8'h0F, 8'h01);
        wr(8'hBE, 8'h02);
        w(2);
        chk("ie", 8'h7E, 8'(pin_ie));
        chk("pd", 8'h7D, 8'(pin_pd));
    endtask : t_inp

    task automatic results();
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then every scenario in turn.
    initial begin
        {sys_clk, resetn, reg_wr, reg_rd, dirq, sync} = '0;
        {reg_addr, reg_wdata, pin_in, g0, vo} = '0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        w(1);
        chk("oe rst", 8'h00, 8'(pin_oe));
        chk("ie rst", 8'h7F, 8'(pin_ie));
        chk("pd rst", 8'h7F, 8'(pin_pd));
        t_dev();
        t_irq();
        t_vo_fwd();
        t_fwd();
        t_bc();
        t_inp();
        results();
    end
endmodule : serial_link_gpio_mapper_test

`default_nettype wire
